// file: rtl/lmc_top.sv
/*
 * Lookup mask and confirmation stage: profile memory, key masking, key
 * CRC, binary tree walk, post-search confirmation chain, flow table check
 * and default post-search fallback, plus option/TOS treatment lookups.
 * Assumes the parser and the external memory port run on clk.
 */
// Contract
// - Mask the key with the search profile's mask before any CRC.
// - Key bits under a zero mask bit become zero; others pass.
// - For a four-dword key, ignore mask dwords four to nine.
// - Option codes: 00 none, 01 skip, 10 CPU via fragments, 11 delete.
// - Entry N holds option codes for values N*16 to N*16+15.
// - TOS codes: 00 keep, 01 reserved, 10 low, 11 high priority.
// - Entry N holds TOS codes for values N*16 to N*16+15.
// - Walk the tree with the 60-bit key until an equal node.
// - A confirmation structure matches only when stored headers equal the key headers.
// - With flow check on, flow bit one validates, zero fails.
// - Flow table is a 256-bit bitmap at the flow table pointer.
// - On failure, follow the next confirmation pointer if present.
// - No match or no tree node: use the profile's default structure.
// - Default structure deletes, sends to CPU, or restarts with new profile.
// - Default structure of profile P is at 1800h plus P times 80h.
// - A profile excluding SSRC zeroes key dword three through its mask.
// - Search key is the 56-bit CRC followed by the 4-bit profile.
// - The 56-bit CRC joins a CRC-32, CRC-16 and CRC-8.
// - A second confirmation match is a configuration error flag.
`timescale 1ns/1ps
`default_nettype none
module lmc_top
	import lmc_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic prof_wr_en,
	input wire logic [3:0] prof_wr_idx,
	input wire lmc_pkg::lmc_prof_s prof_wr_data,
	input wire logic [7:0] opt_value,
	input wire logic [1:0] opt_sel,
	input wire logic [7:0] tos_value,
	input wire logic tos_v6,
	output logic [1:0] ipv4_option_treatment,
	output logic [1:0] hop_by_hop_option_treatment,
	output logic [1:0] destination_option_treatment,
	output logic [1:0] ipv4_tos_treatment,
	output logic [1:0] ipv6_tos_treatment,
	output lmc_pkg::lmc_opt_e opt_action,
	output lmc_pkg::lmc_tos_e tos_action,
	input wire logic in_valid,
	output logic in_ready,
	input wire lmc_pkg::lmc_req_s in_req,
	output logic mem_req,
	output lmc_pkg::lmc_kind_e mem_kind,
	output logic [23:0] mem_addr,
	input wire logic mem_gnt,
	input wire logic mem_rvalid,
	input wire lmc_pkg::lmc_mrsp_s mem_rsp,
	output logic res_valid,
	output lmc_pkg::lmc_res_s res,
	output logic cfg_err,
	input wire logic cfg_err_clr
);
	import lmc_pkg::*;

	logic [1:0] rst_pipe_q;
	logic rst_n;
	lmc_prof_s prof_mem_q [PROF_CNT];
	lmc_st_e st_q;
	lmc_kind_e kind_q;
	lmc_req_s req_q;
	logic [3:0] prof_q;
	logic [319:0] masked_q;
	logic [59:0] key60_q;
	logic [23:0] addr_q;
	logic [4:0] chain_q;
	logic [2:0] reent_q;
	logic matched_q;
	logic [3:0] mdest_q;
	logic [3:0] dest_q;
	logic [23:0] next_q;
	logic [7:0] idx_q;
	lmc_res_s res_q;
	logic [319:0] mask_eff;
	logic [55:0] crc56;
	logic [23:0] dflt_addr;
	logic [23:0] ft_addr;
	logic hdr_ok, need_ft, ok, dbl;
	logic [23:0] nxt;
	logic [3:0] dest_eff;
	logic [23:0] child;

	// Reset release through two flops; assertion is immediate
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rst_pipe_q <= 2'b00;
		else
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
	end
	assign rst_n = rst_pipe_q[1];

	// Profile memory, one write port; each entry is a plain flop bank
	for (genvar g = 0; g < PROF_CNT; g++)
	begin : g_prof
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
				prof_mem_q[g] <= {MASK_RST, CODES_RST, CODES_RST, CODES_RST,
					CODES_RST, CODES_RST};
			else if (prof_wr_en && prof_wr_idx == 4'(g))
				prof_mem_q[g] <= prof_wr_data;
		end
	end

	// Treatment codes: entry by high nibble, code by low nibble
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ipv4_option_treatment <= 2'b00;
			hop_by_hop_option_treatment <= 2'b00;
			destination_option_treatment <= 2'b00;
			ipv4_tos_treatment <= 2'b00;
			ipv6_tos_treatment <= 2'b00;
			opt_action <= OPT_NONE;
			tos_action <= TOS_KEEP;
		end
		else
		begin
			ipv4_option_treatment <= prof_mem_q[opt_value[7:4]].opt_v4[opt_value[3:0]];
			hop_by_hop_option_treatment <= prof_mem_q[opt_value[7:4]].opt_hop[opt_value[3:0]];
			destination_option_treatment <= prof_mem_q[opt_value[7:4]].opt_dst[opt_value[3:0]];
			ipv4_tos_treatment <= prof_mem_q[tos_value[7:4]].tos_v4[tos_value[3:0]];
			ipv6_tos_treatment <= prof_mem_q[tos_value[7:4]].tos_v6[tos_value[3:0]];
			case (opt_sel)
				2'b00: opt_action <= lmc_opt_e'(prof_mem_q[opt_value[7:4]].opt_v4[opt_value[3:0]]);
				2'b01: opt_action <= lmc_opt_e'(prof_mem_q[opt_value[7:4]].opt_hop[opt_value[3:0]]);
				2'b10: opt_action <= lmc_opt_e'(prof_mem_q[opt_value[7:4]].opt_dst[opt_value[3:0]]);
				default: opt_action <= OPT_NONE;
			endcase
			// Reserved code acts as no change
			case (tos_v6 ? prof_mem_q[tos_value[7:4]].tos_v6[tos_value[3:0]]
				: prof_mem_q[tos_value[7:4]].tos_v4[tos_value[3:0]])
				2'b10: tos_action <= TOS_LOW;
				2'b11: tos_action <= TOS_HIGH;
				default: tos_action <= TOS_KEEP;
			endcase
		end
	end

	// Effective mask; a short key has no dwords 4-9 so they are dropped
	assign mask_eff = req_q.len4 ? {192'h0, prof_mem_q[prof_q].mask[127:0]}
		: prof_mem_q[prof_q].mask;

	lmc_crc u_crc (
		.key(masked_q),
		.crc56(crc56)
	);

	// Fixed-address fetches
	assign dflt_addr = DFLT_BASE + 24'(prof_q) * DFLT_STEP;
	assign ft_addr = req_q.ft_ptr + 24'({mem_rsp.ip_idx[7:5], 2'b00});

	// Confirmation verdict for the current response
	always_comb
	begin
		hdr_ok = mem_rsp.hdr == masked_q;
		need_ft = kind_q == K_CONF && hdr_ok && mem_rsp.ft_en;
		if (kind_q == K_CONF)
			ok = hdr_ok && !mem_rsp.ft_en;
		else
			ok = mem_rsp.ft_word[idx_q[4:0]];
		nxt = kind_q == K_CONF ? mem_rsp.link : next_q;
		dest_eff = kind_q == K_CONF ? mem_rsp.dest : dest_q;
		child = key60_q < mem_rsp.key ? mem_rsp.left : mem_rsp.right;
		dbl = st_q == S_MWAIT && mem_rvalid && (kind_q == K_CONF || kind_q == K_FT)
			&& !need_ft && ok && matched_q && chain_q != CHAIN_MAX;
	end

	// Search walk
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= S_IDLE;
			kind_q <= K_NODE;
			req_q <= '0;
			prof_q <= 4'h0;
			masked_q <= '0;
			key60_q <= '0;
			addr_q <= 24'h00_0000;
			chain_q <= 5'h00;
			reent_q <= 3'h0;
			matched_q <= 1'b0;
			mdest_q <= 4'h0;
			dest_q <= 4'h0;
			next_q <= 24'h00_0000;
			idx_q <= 8'h00;
			res_q <= '0;
		end
		else
		begin
			case (st_q)
				S_IDLE:
				begin
					if (in_valid)
					begin
						req_q <= in_req;
						prof_q <= in_req.prof;
						reent_q <= 3'h0;
						st_q <= S_KEY;
					end
				end
				S_KEY:
				begin
					// Per-profile mask, e.g. zero dword 3 to leave out SSRC
					masked_q <= req_q.key & mask_eff;
					chain_q <= 5'h00;
					matched_q <= 1'b0;
					st_q <= S_CRC;
				end
				S_CRC:
				begin
					key60_q <= {crc56, prof_q};
					st_q <= S_MREQ;
					if (req_q.root == 24'h00_0000)
					begin
						kind_q <= K_DFLT;
						addr_q <= dflt_addr;
					end
					else
					begin
						kind_q <= K_NODE;
						addr_q <= req_q.root;
					end
				end
				S_MREQ:
				begin
					if (mem_gnt)
						st_q <= S_MWAIT;
				end
				S_MWAIT:
				begin
					if (mem_rvalid)
					begin
						st_q <= S_MREQ;
						case (kind_q)
							K_NODE:
							begin
								if (mem_rsp.key == key60_q && mem_rsp.link != 24'h00_0000)
								begin
									kind_q <= K_CONF;
									addr_q <= mem_rsp.link;
								end
								else if (mem_rsp.key != key60_q && child != 24'h00_0000)
									addr_q <= child;
								else
								begin
									kind_q <= K_DFLT;
									addr_q <= dflt_addr;
								end
							end
							K_DFLT:
							begin
								res_q.prof <= prof_q;
								res_q.dest <= 4'h0;
								case (mem_rsp.dact)
									ACT_DEL:
									begin
										res_q.act <= ACT_DEL;
										st_q <= S_DONE;
									end
									ACT_RESTART:
									begin
										if (reent_q == REENT_MAX)
										begin
											res_q.act <= ACT_CPU;
											st_q <= S_DONE;
										end
										else
										begin
											prof_q <= mem_rsp.nprof;
											reent_q <= reent_q + 3'h1;
											st_q <= S_KEY;
										end
									end
									default:
									begin
										res_q.act <= ACT_CPU;
										st_q <= S_DONE;
									end
								endcase
							end
							default:
							begin
								// Confirmation structure or its flow table word
								if (kind_q == K_CONF)
								begin
									chain_q <= chain_q + 5'h01;
									next_q <= mem_rsp.link;
									dest_q <= mem_rsp.dest;
									idx_q <= mem_rsp.ip_idx;
								end
								res_q.prof <= prof_q;
								if (kind_q == K_CONF && chain_q == CHAIN_MAX)
								begin
									res_q.act <= ACT_CPU;
									res_q.dest <= 4'h0;
									st_q <= S_DONE;
								end
								else if (need_ft)
								begin
									kind_q <= K_FT;
									addr_q <= ft_addr;
								end
								else if (dbl)
								begin
									// Second hit: keep the first one
									res_q.act <= ACT_ROUTE;
									res_q.dest <= mdest_q;
									st_q <= S_DONE;
								end
								else if (nxt != 24'h00_0000)
								begin
									// Walk on even after a hit, to catch a duplicate
									if (ok)
									begin
										matched_q <= 1'b1;
										mdest_q <= dest_eff;
									end
									kind_q <= K_CONF;
									addr_q <= nxt;
								end
								else if (ok || matched_q)
								begin
									res_q.act <= ACT_ROUTE;
									res_q.dest <= ok ? dest_eff : mdest_q;
									st_q <= S_DONE;
								end
								else
								begin
									kind_q <= K_DFLT;
									addr_q <= dflt_addr;
								end
							end
						endcase
					end
				end
				S_DONE:
					st_q <= S_IDLE;
				default:
					st_q <= S_IDLE;
			endcase
		end
	end

	// Sticky error flag; a new error wins over a clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cfg_err <= 1'b0;
		else if (dbl)
			cfg_err <= 1'b1;
		else if (cfg_err_clr)
			cfg_err <= 1'b0;
	end

	assign in_ready = st_q == S_IDLE;
	assign mem_req = st_q == S_MREQ;
	assign mem_kind = kind_q;
	assign mem_addr = addr_q;
	assign res_valid = st_q == S_DONE;
	assign res = res_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_mask_zero;
		st_q == S_CRC |-> (masked_q & ~$past(mask_eff)) == 320'h0;
	endproperty
	a_mask_zero: assert property (p_mask_zero) else $error("masked bit not zero");
	property p_short_key;
		st_q == S_CRC && req_q.len4 |-> masked_q[319:128] == 192'h0;
	endproperty
	a_short_key: assert property (p_short_key) else $error("short key high dwords set");
	property p_key60;
		$rose(st_q == S_MREQ) && kind_q == K_NODE && $past(st_q) == S_CRC
			|-> key60_q == {$past(crc56), prof_q};
	endproperty
	a_key60: assert property (p_key60) else $error("search key malformed");
	property p_dflt_addr;
		mem_req && mem_kind == K_DFLT |-> mem_addr == 24'h00_1800 + {13'h0, prof_q, 7'h00};
	endproperty
	a_dflt_addr: assert property (p_dflt_addr) else $error("default address wrong");
	property p_ft_addr;
		mem_req && mem_kind == K_FT
			|-> mem_addr == req_q.ft_ptr + {19'h0, idx_q[7:5], 2'b00};
	endproperty
	a_ft_addr: assert property (p_ft_addr) else $error("flow table address wrong");
	property p_tos_low;
		tos_action == TOS_LOW |-> $past(tos_v6) ? ipv6_tos_treatment == 2'b10
			: ipv4_tos_treatment == 2'b10;
	endproperty
	a_tos_low: assert property (p_tos_low) else $error("low priority without code");
	property p_opt_del;
		opt_action == OPT_DEL && $past(opt_sel) == 2'b00 |-> ipv4_option_treatment == 2'b11;
	endproperty
	a_opt_del: assert property (p_opt_del) else $error("delete without code");
	property p_err_set;
		dbl |=> cfg_err && res_valid;
	endproperty
	a_err_set: assert property (p_err_set) else $error("double match not flagged");
	property p_chain_cap;
		st_q == S_MREQ && kind_q == K_CONF |-> chain_q <= CHAIN_MAX;
	endproperty
	a_chain_cap: assert property (p_chain_cap) else $error("chain walk unbounded");
	property p_ft_zero;
		st_q == S_MWAIT && mem_rvalid && kind_q == K_FT && !mem_rsp.ft_word[idx_q[4:0]]
			&& next_q == 24'h00_0000 && !matched_q
			|=> mem_req && mem_kind == K_DFLT;
	endproperty
	a_ft_zero: assert property (p_ft_zero) else $error("failed flow check not defaulted");

	c_route: cover property (res_valid && res.act == ACT_ROUTE);
	c_restart: cover property (st_q == S_MWAIT && mem_rvalid && kind_q == K_DFLT
		&& mem_rsp.dact == ACT_RESTART);
	c_ft: cover property (mem_req && mem_kind == K_FT);
	c_err: cover property (dbl);
endmodule
`default_nettype wire

// file: rtl/lmc_pkg.sv
/*
 * Package for the lookup mask and confirmation stage: timing and address
 * constants, profile memory layout, request/response carriers, enums.
 * Assumes a single core clock; external memory returns decoded structures.
 */
package lmc_pkg;
	// Profile memory and key geometry
	localparam int KEY_BITS = 320;
	localparam int KEY4_BITS = 128;
	localparam int PROF_CNT = 16;
	localparam int ADDR_W = 24;
	// Default post-search structures sit at a fixed base, one per profile
	localparam logic [23:0] DFLT_BASE = 24'h00_1800;
	localparam logic [23:0] DFLT_STEP = 24'h00_0080;
	// Walk bounds per packet
	localparam logic [4:0] CHAIN_MAX = 5'h10;
	localparam logic [2:0] REENT_MAX = 3'h4;
	// CRC polynomials, all registers start from zero
	localparam logic [31:0] POLY32 = 32'h04C1_1DB7;
	localparam logic [31:0] POLY16 = 32'h0000_1021;
	localparam logic [31:0] POLY8 = 32'h0000_0007;
	// Profile memory reset: mask passes everything, all codes zero
	localparam logic [319:0] MASK_RST = '1;
	localparam logic [31:0] CODES_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_KEY = 3'b001,
		S_CRC = 3'b010,
		S_MREQ = 3'b011,
		S_MWAIT = 3'b100,
		S_DONE = 3'b101
	} lmc_st_e;

	typedef enum logic [1:0] {
		K_NODE = 2'b00,
		K_CONF = 2'b01,
		K_FT = 2'b10,
		K_DFLT = 2'b11
	} lmc_kind_e;

	// Final actions; also the default-structure action codes
	typedef enum logic [1:0] {
		ACT_ROUTE = 2'b00,
		ACT_DEL = 2'b01,
		ACT_CPU = 2'b10,
		ACT_RESTART = 2'b11
	} lmc_act_e;

	typedef enum logic [1:0] {
		OPT_NONE = 2'b00,
		OPT_SKIP = 2'b01,
		OPT_CPU = 2'b10,
		OPT_DEL = 2'b11
	} lmc_opt_e;

	typedef enum logic [1:0] {
		TOS_KEEP = 2'b00,
		TOS_RSVD = 2'b01,
		TOS_LOW = 2'b10,
		TOS_HIGH = 2'b11
	} lmc_tos_e;

	typedef struct packed {
		logic [319:0] mask;
		logic [15:0][1:0] opt_v4;
		logic [15:0][1:0] opt_hop;
		logic [15:0][1:0] opt_dst;
		logic [15:0][1:0] tos_v4;
		logic [15:0][1:0] tos_v6;
	} lmc_prof_s;

	typedef struct packed {
		logic [319:0] key;
		logic len4;
		logic [3:0] prof;
		logic [23:0] ft_ptr;
		logic [23:0] root;
	} lmc_req_s;

	typedef struct packed {
		logic [59:0] key;
		logic [23:0] left;
		logic [23:0] right;
		logic [23:0] link;
		logic [319:0] hdr;
		logic [7:0] ip_idx;
		logic ft_en;
		logic [3:0] dest;
		lmc_act_e dact;
		logic [3:0] nprof;
		logic [31:0] ft_word;
	} lmc_mrsp_s;

	typedef struct packed {
		lmc_act_e act;
		logic [3:0] dest;
		logic [3:0] prof;
	} lmc_res_s;
endpackage

// file: rtl/lmc_crc.sv
/*
 * Combinational CRC-8, CRC-16 and CRC-32 over the masked key,
 * packed into one 56-bit result. Assumes the caller registers the output.
 */
`timescale 1ns/1ps
`default_nettype none
module lmc_crc
	import lmc_pkg::*;
(
	input wire logic [319:0] key,
	output logic [55:0] crc56
);
	// Bit-serial CRC, MSB of the key first; w selects the register width
	function automatic logic [31:0] crc_calc(input logic [319:0] d,
		input logic [31:0] poly, input int w);
		logic [31:0] c;
		logic fb;
		c = 32'h0000_0000;
		for (int i = 0; i < KEY_BITS; i++)
		begin
			fb = c[w-1] ^ d[KEY_BITS-1-i];
			c = c << 1;
			if (fb)
				c = c ^ poly;
		end
		return c & 32'((33'h1_0000_0000 >> (32 - w)) - 33'h0_0000_0001);
	endfunction

	// CRC-8 on top, CRC-16 in the middle, CRC-32 at the bottom
	logic [31:0] c8, c16, c32;
	always_comb
	begin
		c8 = crc_calc(key, POLY8, 8);
		c16 = crc_calc(key, POLY16, 16);
		c32 = crc_calc(key, POLY32, 32);
		crc56 = {c8[7:0], c16[15:0], c32};
	end
endmodule
`default_nettype wire

// file: tb/lmc_mem_model.sv
/*
 * Behavioural external memory for the lookup stage, holding decoded structures by address.
 * Assumes one read outstanding and a request held until granted.
 */
`timescale 1ns/1ps
`default_nettype none
module lmc_mem_model
	import lmc_pkg::*;
(
	input wire logic clk,
	input wire logic mem_req,
	input wire logic [23:0] mem_addr,
	output logic mem_gnt,
	output logic mem_rvalid,
	output lmc_pkg::lmc_mrsp_s mem_rsp
);
	lmc_mrsp_s mem [int];
	lmc_mrsp_s rd_q;
	int lat_q = 0;
	initial
	begin
		mem_gnt = 1'b0;
		mem_rvalid = 1'b0;
		mem_rsp = '0;
	end
	// Random grant and return delay; data toggles while not valid so stale values never pass
	always @(posedge clk)
	begin
		mem_gnt <= 1'b0;
		mem_rvalid <= 1'b0;
		mem_rsp <= ~mem_rsp;
		if (lat_q > 0)
		begin
			lat_q <= lat_q - 1;
			if (lat_q == 1)
			begin
				mem_rvalid <= 1'b1;
				mem_rsp <= rd_q;
			end
		end
		else if (mem_req && !mem_gnt && $urandom_range(1, 0) == 1)
		begin
			mem_gnt <= 1'b1;
			rd_q <= mem.exists(int'(mem_addr)) ? mem[int'(mem_addr)] : '0;
			lat_q <= $urandom_range(4, 1);
		end
	end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
/*
 * Self-checking bench for the lookup mask and confirmation stage.
 * Assumes the memory model answers from structures that the bench places in it.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lmc_pkg::*;
	localparam logic [23:0] FTP = 24'h00_3000;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic prof_wr_en = 1'b0;
	logic [3:0] prof_wr_idx = '0;
	lmc_prof_s prof_wr_data = '0;
	logic [7:0] opt_value = '0;
	logic [1:0] opt_sel = '0;
	logic [7:0] tos_value = '0;
	logic tos_v6 = 1'b0;
	logic [1:0] o4, oh, od, t4, t6;
	lmc_opt_e opt_action;
	lmc_tos_e tos_action;
	logic in_valid = 1'b0;
	logic in_ready, mem_req, mem_gnt, mem_rvalid, res_valid, cfg_err;
	logic cfg_err_clr = 1'b0;
	lmc_req_s in_req = '0;
	logic [23:0] mem_addr;
	lmc_kind_e mem_kind;
	lmc_mrsp_s mem_rsp;
	lmc_res_s res;
	lmc_prof_s pm [16];
	lmc_res_s exq [$];
	int err_total = 0;
	int n_checks = 0;

	always #4 clk = ~clk;

	lmc_top u_dut (.clk(clk), .reset_n(reset_n), .prof_wr_en(prof_wr_en),
		.prof_wr_idx(prof_wr_idx), .prof_wr_data(prof_wr_data), .opt_value(opt_value),
		.opt_sel(opt_sel), .tos_value(tos_value), .tos_v6(tos_v6),
		.ipv4_option_treatment(o4), .hop_by_hop_option_treatment(oh),
		.destination_option_treatment(od), .ipv4_tos_treatment(t4),
		.ipv6_tos_treatment(t6), .opt_action(opt_action), .tos_action(tos_action),
		.in_valid(in_valid), .in_ready(in_ready), .in_req(in_req), .mem_req(mem_req),
		.mem_kind(mem_kind), .mem_addr(mem_addr), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
		.mem_rsp(mem_rsp), .res_valid(res_valid), .res(res), .cfg_err(cfg_err),
		.cfg_err_clr(cfg_err_clr));
	lmc_mem_model u_mem (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rsp(mem_rsp));

	task automatic finish_test();
		if (exq.size() != 0)
		begin
			err_total++;
			$display("Error result queue expected 0 seen %0d", exq.size());
		end
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk_code(input string nm, input logic [1:0] e, input logic [1:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	// Destination only means something on a routed result
	task automatic chk_res(input lmc_res_s e, input lmc_res_s g);
		n_checks++;
		if (g.act !== e.act || (e.act == ACT_ROUTE && g.dest !== e.dest))
		begin
			err_total++;
			$display("Error result expected %0h/%0h seen %0h/%0h", e.act, e.dest, g.act, g.dest);
		end
	endtask
	// Each result pulse retires the oldest expectation
	always @(posedge clk)
		if (res_valid === 1'b1)
		begin
			if (exq.size() == 0)
			begin
				err_total++;
				$display("Error result expected none seen %0h", res.act);
			end
			else
				chk_res(exq.pop_front(), res);
		end

	// Bench layout: nodes below 200h, confirmations below 1800h, defaults, then flow table
	function automatic logic [1:0] kind_at(input logic [23:0] a);
		if (a >= FTP)
			return K_FT;
		else if (a >= 24'h00_1800)
			return K_DFLT;
		else if (a >= 24'h00_0200)
			return K_CONF;
		else
			return K_NODE;
	endfunction
	// Each granted fetch must carry the kind of structure placed at that address
	always @(negedge clk)
		if (mem_req === 1'b1 && mem_gnt === 1'b1)
			chk_code("mem kind", kind_at(mem_addr), mem_kind);

	function automatic logic [1:0] optx(input int v);
		case (v[1:0])
			2'd0: return pm[v[7:4]].opt_v4[v[3:0]];
			2'd1: return pm[v[7:4]].opt_hop[v[3:0]];
			2'd2: return pm[v[7:4]].opt_dst[v[3:0]];
			default: return 2'b00;
		endcase
	endfunction
	// Reserved priority code behaves as keep
	function automatic logic [1:0] tosx(input int v);
		logic [1:0] c;
		c = v[2] ? pm[v[7:4]].tos_v6[v[3:0]] : pm[v[7:4]].tos_v4[v[3:0]];
		return (c == 2'b01) ? 2'b00 : c;
	endfunction
	function automatic lmc_mrsp_s st(input logic [59:0] k, input logic [23:0] lf,
		input logic [23:0] rt, input logic [23:0] lk, input logic [319:0] h,
		input logic fe, input logic [3:0] d);
		st = '0;
		st.key = k;
		st.left = lf;
		st.right = rt;
		st.link = lk;
		st.hdr = h;
		st.ip_idx = 8'hA5;
		st.ft_en = fe;
		st.dest = d;
	endfunction
	function automatic lmc_mrsp_s dfl(input lmc_act_e a, input logic [3:0] np);
		dfl = '0;
		dfl.dact = a;
		dfl.nprof = np;
	endfunction
	function automatic lmc_mrsp_s ftw(input logic [31:0] w);
		ftw = '0;
		ftw.ft_word = w;
	endfunction
	function automatic logic [319:0] rnd();
		return {{6{$urandom()}}, {4{$urandom()}}};
	endfunction

	// One search at a time; bounded waits for acceptance and result
	task automatic search(input logic [319:0] k, input logic l4, input logic [3:0] p,
		input logic [23:0] rt, input lmc_act_e a, input logic [3:0] d);
		int n;
		exq.push_back('{a, d, p});
		@(posedge clk);
		in_valid <= 1'b1;
		in_req <= '{k, l4, p, FTP, rt};
		n = 0;
		@(negedge clk);
		while (in_ready !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		if (in_ready !== 1'b1)
		begin
			err_total++;
			$display("Error search accept expected ready seen %b", in_ready);
			finish_test();
		end
		@(posedge clk);
		in_valid <= 1'b0;
		n = 0;
		@(negedge clk);
		while (res_valid !== 1'b1)
		begin
			@(negedge clk);
			n++;
			if (n > 3000)
			begin
				err_total++;
				$display("Error search timeout expected result seen none");
				finish_test();
			end
		end
	endtask

	initial
	begin
		void'($urandom(51713));
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		// Low four key dwords masked out, upper six passed, random treatment codes
		for (int i = 0; i < 16; i++)
		begin
			pm[i] = {{6{32'hFFFF_FFFF}}, 128'h0, $urandom(), $urandom(), $urandom(),
				$urandom(), $urandom()};
			@(posedge clk);
			prof_wr_en <= 1'b1;
			prof_wr_idx <= i[3:0];
			prof_wr_data <= pm[i];
		end
		@(posedge clk);
		prof_wr_en <= 1'b0;
		for (int v = 0; v < 256; v++)
		begin
			@(posedge clk);
			opt_value <= v[7:0];
			tos_value <= v[7:0];
			opt_sel <= v[1:0];
			tos_v6 <= v[2];
			@(posedge clk);
			@(negedge clk);
			chk_code("opt v4", pm[v[7:4]].opt_v4[v[3:0]], o4);
			chk_code("opt hop", pm[v[7:4]].opt_hop[v[3:0]], oh);
			chk_code("opt dst", pm[v[7:4]].opt_dst[v[3:0]], od);
			chk_code("tos v4", pm[v[7:4]].tos_v4[v[3:0]], t4);
			chk_code("tos v6", pm[v[7:4]].tos_v6[v[3:0]], t6);
			chk_code("opt act", optx(v), opt_action);
			chk_code("tos act", tosx(v), tos_action);
		end
		$display("Test treatment lookups done");
		// Empty tree sends every profile to its own default structure
		for (int p = 0; p < 16; p++)
			u_mem.mem[32'h0000_1800 + p * 32'h0000_0080] = dfl(lmc_act_e'(p % 3), 4'h0);
		for (int p = 0; p < 16; p++)
			search(rnd(), 1'b1, p[3:0], 24'h00_0000, p % 3 == 1 ? ACT_DEL : ACT_CPU, 4'h0);
		u_mem.mem[32'h0000_1900] = dfl(ACT_RESTART, 4'h3);
		u_mem.mem[32'h0000_1980] = dfl(ACT_DEL, 4'h0);
		search(rnd(), 1'b1, 4'h2, 24'h00_0000, ACT_DEL, 4'h0);
		u_mem.mem[32'h0000_1A00] = dfl(ACT_RESTART, 4'h4);
		search(rnd(), 1'b1, 4'h4, 24'h00_0000, ACT_CPU, 4'h0);
		$display("Test default structures done");
		// Masked key is all zero, so the key is zero CRC plus profile
		u_mem.mem[32'h0000_0100] = st({56'h0, 4'h5}, 0, 0, 24'h00_0200, 320'h0, 1'b0, 4'h0);
		u_mem.mem[32'h0000_0200] = st(60'h0, 0, 0, 0, 320'h0, 1'b1, 4'h7);
		u_mem.mem[FTP + 32'h0000_0014] = ftw(32'h0000_0020);
		search(rnd(), 1'b1, 4'h5, 24'h00_0100, ACT_ROUTE, 4'h7);
		u_mem.mem[FTP + 32'h0000_0014] = ftw(32'hFFFF_FFDF);
		search(rnd(), 1'b1, 4'h5, 24'h00_0100, ACT_CPU, 4'h0);
		u_mem.mem[32'h0000_0200] = st(60'h0, 0, 0, 24'h00_0280, '1, 1'b0, 4'h7);
		u_mem.mem[32'h0000_0280] = st(60'h0, 0, 0, 0, 320'h0, 1'b0, 4'h9);
		search({192'h0, {4{$urandom()}}}, 1'b0, 4'h5, 24'h00_0100, ACT_ROUTE, 4'h9);
		u_mem.mem[32'h0000_0200] = st(60'h0, 0, 0, 24'h00_0280, 320'h0, 1'b0, 4'h4);
		search(rnd(), 1'b1, 4'h5, 24'h00_0100, ACT_ROUTE, 4'h4);
		repeat (2) @(negedge clk);
		chk_code("cfg err", 2'b01, {1'b0, cfg_err});
		@(posedge clk);
		cfg_err_clr <= 1'b1;
		@(posedge clk);
		cfg_err_clr <= 1'b0;
		@(negedge clk);
		chk_code("cfg err clr", 2'b00, {1'b0, cfg_err});
		$display("Test confirmation chain done");
		// Tree direction: larger node key goes left, smaller goes right
		u_mem.mem[32'h0000_0280] = st(60'h0, 0, 0, 0, 320'h0, 1'b0, 4'h9);
		u_mem.mem[32'h0000_0180] = st({56'h0, 4'h5}, 0, 0, 24'h00_0280, 320'h0, 1'b0, 4'h0);
		u_mem.mem[32'h0000_0100] = st({56'h1, 4'h5}, 0, 24'h00_0180, 0, 320'h0, 1'b0, 4'h0);
		search(rnd(), 1'b1, 4'h5, 24'h00_0100, ACT_CPU, 4'h0);
		u_mem.mem[32'h0000_0100] = st({56'h0, 4'h4}, 0, 24'h00_0180, 0, 320'h0, 1'b0, 4'h0);
		search(rnd(), 1'b1, 4'h5, 24'h00_0100, ACT_ROUTE, 4'h9);
		$display("Test tree walk done");
		repeat (5) @(posedge clk);
		finish_test();
	end
endmodule
`default_nettype wire
